// ---- design/owb_pkg.sv ----
// Package of constants shared by both ends of the one-wire brightness link
package owb_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ            = 10_000_000;
	localparam int START_TIME_NS     = 2000;
	localparam int EOS_TIME_NS       = 2000;
	localparam int ACK_PULSE_TIME_NS = 512_000;
	localparam int ACK_VALID_DELAY_NS = 4000;
	localparam int BIT_UNIT_NS       = 2000;
	localparam int START_CYC     = (START_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int EOS_CYC       = (EOS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int ACK_PULSE_CYC = (ACK_PULSE_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
	localparam int ACK_DELAY_CYC = (ACK_VALID_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int BIT_UNIT_CYC  = (BIT_UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Long high that abandons a partial byte; must outlast the longest bit high
	localparam int HIGH_CLOSE_CYC = 4 * BIT_UNIT_CYC;
	// End-of-stream as measured behind the synchroniser, which loses a few cycles
	localparam int EOS_DET_CYC    = EOS_CYC - 3;
	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int BYTE_BITS       = 8;
	localparam int FRAME_BITS      = 16;
	localparam int ACK_FLAG_POS    = 7;
	localparam int REG_ADDR_HI_POS = 6;
	localparam int REG_ADDR_LO_POS = 5;
	localparam int LEVEL_WIDTH     = 5;
	localparam logic [4:0] LEVEL_RESET = 5'h00;
	localparam int CNT_W = 16;
	// Arbitrary address value, not tied to any product
	localparam logic [7:0] DEV_ADDR_DEFAULT = 8'h5A;
endpackage : owb_pkg

// ---- design/owb_link_if.sv ----
// Interface joining the open-drain control wire between host and device
`timescale 1ns/100ps
interface owb_link_if;
	logic host_oe;   // Host pulls wire low
	logic dev_oe;    // Device pulls wire low
	logic wire_lvl;  // Resolved level, pulled up when nobody drives
	assign wire_lvl = ~(host_oe | dev_oe);
	modport host_mp (output host_oe, input wire_lvl);
	modport dev_mp  (output dev_oe,  input wire_lvl);
endinterface : owb_link_if

// ---- design/owb_fifo.sv ----
// Parameterised valid/ready FIFO for host command words
`timescale 1ns/100ps
module owb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output      logic             in_ready,
	output      logic [WIDTH-1:0] out_data,
	output      logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// Handshakes
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rd_r];

	// Storage writes
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (pop)  rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : owb_fifo

// ---- design/owb_host.sv ----
// Host end: queues command words and sends them as coded frames on the wire
`timescale 1ns/100ps
module owb_host #(
	parameter int ACK_PULSE_CYCLES = owb_pkg::ACK_PULSE_CYC,
	parameter logic [7:0] DEV_ADDR = owb_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	owb_link_if.host_mp      link,
	input  wire logic [5:0]  cmd_data,
	input  wire logic        cmd_valid,
	output      logic        cmd_ready,
	input  wire logic        open_drain,
	output      logic        busy,
	output      logic        done,
	output      logic        acked
);
	typedef enum {H_IDLE, H_START, H_LOW, H_HIGH, H_EOS, H_VAL, H_SAMPLE, H_WAIT} owb_hst_e;
	owb_hst_e          st_r;
	logic [5:0]        q_data;
	logic              q_valid;
	logic              q_ready;
	logic [15:0]       sh_r;
	logic [4:0]        bit_r;
	logic [owb_pkg::CNT_W-1:0] cnt_r;
	logic [owb_pkg::CNT_W-1:0] lo_len;
	logic [owb_pkg::CNT_W-1:0] hi_len;
	logic              s1_r;
	logic              s2_r;
	logic              req_r;

	// Command queue absorbs bursts while the wire is busy
	owb_fifo #(.WIDTH(6), .DEPTH(32)) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_data   (cmd_data),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.out_data  (q_data),
		.out_valid (q_valid),
		.out_ready (q_ready)
	);
	assign q_ready = (st_r == H_IDLE);
	assign busy    = (st_r != H_IDLE);

	// Bit shape: one is short low then long high, zero the reverse
	assign lo_len = sh_r[15] ? owb_pkg::CNT_W'(owb_pkg::BIT_UNIT_CYC) : owb_pkg::CNT_W'(3*owb_pkg::BIT_UNIT_CYC);
	assign hi_len = sh_r[15] ? owb_pkg::CNT_W'(3*owb_pkg::BIT_UNIT_CYC) : owb_pkg::CNT_W'(owb_pkg::BIT_UNIT_CYC);

	// Wire readback synchroniser
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
		end else begin
			s1_r <= link.wire_lvl;
			s2_r <= s1_r;
		end
	end

	// Frame sequencer
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r         <= H_IDLE;
			sh_r         <= '0;
			bit_r        <= '0;
			cnt_r        <= '0;
			req_r        <= 1'b0;
			link.host_oe <= 1'b0;
			done         <= 1'b0;
			acked        <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_r)
				H_IDLE: begin
					link.host_oe <= 1'b0;
					if (q_valid) begin
						// Flag only with an open-drain stage; register address bits sent as zero
						req_r <= q_data[5] & open_drain;
						sh_r  <= {DEV_ADDR, q_data[5] & open_drain, 2'b00, q_data[4:0]};
						bit_r <= '0;
						cnt_r <= '0;
						st_r  <= H_START;
					end
				end
				H_START: begin
					// Hold high before each byte
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r >= owb_pkg::CNT_W'(owb_pkg::START_CYC)) begin
						cnt_r        <= '0;
						link.host_oe <= 1'b1;
						st_r         <= H_LOW;
					end
				end
				H_LOW: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r + 1'b1 >= lo_len) begin
						cnt_r        <= '0;
						link.host_oe <= 1'b0;
						st_r         <= H_HIGH;
					end
				end
				H_HIGH: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r + 1'b1 >= hi_len) begin
						cnt_r <= '0;
						sh_r  <= {sh_r[14:0], 1'b0};
						bit_r <= bit_r + 1'b1;
						if (bit_r == 5'd7 || bit_r == 5'd15) begin
							// Final falling edge, then end of stream
							link.host_oe <= 1'b1;
							st_r         <= H_EOS;
						end else begin
							link.host_oe <= 1'b1;
							st_r         <= H_LOW;
						end
					end
				end
				H_EOS: begin
					cnt_r <= cnt_r + 1'b1;
					if (bit_r == 5'd16 && req_r) begin
						// Keep low through validation delay
						cnt_r <= '0;
						st_r  <= H_VAL;
					end else if (cnt_r + 1'b1 >= owb_pkg::CNT_W'(owb_pkg::EOS_CYC)) begin
						// Low end-of-stream held, then release for the next start
						cnt_r        <= '0;
						link.host_oe <= 1'b0;
						st_r         <= (bit_r == 5'd16) ? H_WAIT : H_START;
					end
				end
				H_VAL: begin
					cnt_r <= cnt_r + 1'b1;
					// Overlap the device pull-down so the wire never glitches high
					if (cnt_r >= owb_pkg::CNT_W'(owb_pkg::ACK_DELAY_CYC + 5)) begin
						link.host_oe <= 1'b0;
						cnt_r        <= '0;
						st_r         <= H_SAMPLE;
					end
				end
				H_SAMPLE: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == 16'd4) begin
						acked <= ~s2_r;
						cnt_r <= '0;
						st_r  <= H_WAIT;
					end
				end
				H_WAIT: begin
					// Quiet until any acknowledge pulse is over
					cnt_r <= cnt_r + 1'b1;
					if (!req_r || cnt_r >= owb_pkg::CNT_W'(ACK_PULSE_CYCLES)) begin
						done <= 1'b1;
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end
endmodule : owb_host

// ---- design/owb_device.sv ----
// Device end: decodes frames from the wire, applies level, drives acknowledge
`timescale 1ns/100ps
module owb_device #(
	parameter int ACK_PULSE_CYCLES = owb_pkg::ACK_PULSE_CYC,
	parameter logic [7:0] DEV_ADDR = owb_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	owb_link_if.dev_mp       link,
	output      logic [4:0]  level,
	output      logic        level_upd,
	output      logic        ack_active
);
	typedef enum {D_IDLE, D_LOW, D_HIGH, D_VAL, D_ACK} owb_dst_e;
	owb_dst_e                  st_r;
	logic                      s1_r;
	logic                      s2_r;
	logic                      s3_r;
	logic                      fall;
	logic [owb_pkg::CNT_W-1:0] lo_r;
	logic [owb_pkg::CNT_W-1:0] hi_r;
	logic [owb_pkg::CNT_W-1:0] t_r;
	logic [15:0]               sh_r;
	logic [4:0]                n_r;
	logic                      bad_r;
	logic                      eos_r;
	logic                      is_one;
	logic                      is_zero;
	logic                      frame_ok;

	// Two-stage synchroniser plus edge history
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= link.wire_lvl;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign fall = s3_r & ~s2_r;

	// Ratio test; ambiguous bits mark the frame bad
	assign is_one   = (hi_r >= {lo_r[14:0], 1'b0});
	assign is_zero  = (lo_r >= {hi_r[14:0], 1'b0});
	assign frame_ok = (n_r == 5'd16) && !bad_r && (sh_r[15:8] == DEV_ADDR);

	// Decoder and acknowledge sequencer
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r        <= D_IDLE;
			lo_r        <= '0;
			hi_r        <= '0;
			t_r         <= '0;
			sh_r        <= '0;
			n_r         <= '0;
			bad_r       <= 1'b0;
			eos_r       <= 1'b0;
			level       <= owb_pkg::LEVEL_RESET;
			level_upd   <= 1'b0;
			link.dev_oe <= 1'b0;
		end else begin
			level_upd <= 1'b0;
			case (st_r)
				D_IDLE: begin
					// High wire counts as start; first edge opens a bit
					if (fall) begin
						lo_r  <= '0;
						eos_r <= 1'b0;
						st_r  <= D_LOW;
					end
				end
				D_LOW: begin
					lo_r <= lo_r + 1'b1;
					t_r  <= '0;
					if (s2_r) begin
						hi_r <= '0;
						st_r <= D_HIGH;
					end else if (n_r == 5'd16 && sh_r[owb_pkg::ACK_FLAG_POS] && frame_ok) begin
						// Last falling edge seen; start validation timing
						st_r <= D_VAL;
					end else if (eos_r && lo_r >= owb_pkg::CNT_W'(owb_pkg::EOS_DET_CYC)) begin
						// Low end-of-stream closes the byte; a long zero low never does
						if (n_r == 5'd16) begin
							if (frame_ok) begin
								level     <= sh_r[owb_pkg::LEVEL_WIDTH-1:0];
								level_upd <= 1'b1;
							end
							n_r   <= '0;
							bad_r <= 1'b0;
						end
						st_r <= D_IDLE;
					end
				end
				D_HIGH: begin
					hi_r <= hi_r + 1'b1;
					if (fall) begin
						// Closing edge decides the bit
						sh_r  <= {sh_r[14:0], is_one};
						n_r   <= (n_r == 5'd16) ? n_r : n_r + 1'b1;
						bad_r <= bad_r | ~(is_one | is_zero) | (n_r == 5'd16);
						eos_r <= (n_r == 5'd7) || (n_r == 5'd15);
						lo_r  <= '0;
						st_r  <= D_LOW;
					end else if (hi_r >= owb_pkg::CNT_W'(owb_pkg::HIGH_CLOSE_CYC)) begin
						// Long high ends the byte; a partial byte is thrown away
						if (n_r != 5'd8 && n_r != 5'd16) begin
							n_r   <= '0;
							bad_r <= 1'b0;
						end else if (n_r == 5'd16) begin
							n_r   <= '0;
							bad_r <= 1'b0;
						end
						st_r <= D_IDLE;
					end
				end
				D_VAL: begin
					t_r <= t_r + 1'b1;
					if (t_r >= owb_pkg::CNT_W'(owb_pkg::ACK_DELAY_CYC)) begin
						link.dev_oe <= 1'b1;
						level       <= sh_r[owb_pkg::LEVEL_WIDTH-1:0];
						level_upd   <= 1'b1;
						t_r         <= '0;
						st_r        <= D_ACK;
					end
				end
				D_ACK: begin
					// Pulse bounded by the maximum acknowledge time
					t_r <= t_r + 1'b1;
					if (t_r + 1'b1 >= owb_pkg::CNT_W'(ACK_PULSE_CYCLES)) begin
						link.dev_oe <= 1'b0;
						n_r         <= '0;
						bad_r       <= 1'b0;
						st_r        <= D_IDLE;
					end
				end
				default: st_r <= D_IDLE;
			endcase
		end
	end
	assign ack_active = link.dev_oe;
endmodule : owb_device

// ---- dv/owb_link_monitor.sv ----
// Concurrent checks on the shared control wire between host and device
`timescale 1ns/100ps
module owb_link_monitor #(
	parameter int ACK_PULSE_CYCLES = owb_pkg::ACK_PULSE_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic host_oe,
	input wire logic dev_oe,
	input wire logic wire_lvl
);
	localparam int U   = owb_pkg::BIT_UNIT_CYC;
	localparam int DLY = owb_pkg::ACK_DELAY_CYC;
	logic [15:0] lo_r;
	logic [15:0] hi_r;
	logic [15:0] ack_r;
	logic [15:0] fe_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Duration counters
	// ----------------------------------------
	// Saturating, so a long idle span never wraps into a legal length
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lo_r  <= 16'h0000;
			hi_r  <= 16'h0000;
			ack_r <= 16'h0000;
			fe_r  <= 16'h0000;
		end else begin
			lo_r  <= host_oe ? lo_r + {15'h0000, ~&lo_r} : 16'h0000;
			hi_r  <= !host_oe ? hi_r + {15'h0000, ~&hi_r} : 16'h0000;
			ack_r <= dev_oe ? ack_r + {15'h0000, ~&ack_r} : 16'h0000;
			fe_r  <= $rose(host_oe) ? 16'h0001 : fe_r + {15'h0000, ~&fe_r};
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_low_time;
		$fell(host_oe) |-> lo_r == U || lo_r == 3 * U || (lo_r >= DLY && lo_r < 3 * U);
	endproperty
	a_low_time: assert property (p_low_time) else $error("host low pulse of illegal length");
	property p_start_hold;
		$rose(host_oe) |-> hi_r >= owb_pkg::START_CYC;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("wire high too short before fall");
	property p_ack_len;
		$fell(dev_oe) |-> ack_r == ACK_PULSE_CYCLES;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("acknowledge pulse length wrong");
	property p_ack_max;
		ack_r <= ACK_PULSE_CYCLES;
	endproperty
	a_ack_max: assert property (p_ack_max) else $error("acknowledge pulse too long");
	property p_ack_min;
		$rose(dev_oe) |=> dev_oe [*8];
	endproperty
	a_ack_min: assert property (p_ack_min) else $error("acknowledge pulse cut short");
	property p_ack_delay;
		$rose(dev_oe) |-> fe_r >= DLY;
	endproperty
	a_ack_delay: assert property (p_ack_delay) else $error("acknowledge before validation delay");
	property p_ack_follow;
		$fell(host_oe) && lo_r >= DLY && lo_r < 3 * U |-> ##[0:8] dev_oe;
	endproperty
	a_ack_follow: assert property (p_ack_follow) else $error("requested acknowledge missing");
	property p_no_restart;
		dev_oe |-> !$rose(host_oe);
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("host restarted during acknowledge");
	// Main scenarios reached
	c_ack:  cover property ($rose(dev_oe) ##1 !wire_lvl);
	c_one:  cover property ($fell(host_oe) && lo_r == U);
	c_zero: cover property ($fell(host_oe) && lo_r == 3 * U);
endmodule : owb_link_monitor

// ---- dv/one_wire_brightness_cmd_receiver_tb.sv ----
// Testbench joining host and device ends, plus a bench-driven faulty wire
`timescale 1ns/100ps
module one_wire_brightness_cmd_receiver_tb;
	localparam int ACKP = 100;
	logic        clk_sys, reset, cmd_valid, open_drain, cmd_ready, busy, done, acked;
	logic [5:0]  cmd_data;
	logic [4:0]  level, level2, lexp;
	logic        level_upd, level_upd2, ack_active, ack_active2, refused;
	logic [31:0] wire_sh = '0;
	int          fails = 0, total_checks = 0, n_done = 0, n_upd2 = 0, lo_cnt = 0;
	int          acc = 0, n = 0, n_upd = 0, n_ack = 0;
	owb_link_if i_owb_link_if();
	owb_link_if i_owb_link_if_b();
	owb_host #(.ACK_PULSE_CYCLES(ACKP)) i_owb_host (.clk_sys(clk_sys), .reset(reset), .link(i_owb_link_if),
		.cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .open_drain(open_drain),
		.busy(busy), .done(done), .acked(acked));
	owb_device #(.ACK_PULSE_CYCLES(ACKP)) i_owb_device (.clk_sys(clk_sys), .reset(reset),
		.link(i_owb_link_if), .level(level), .level_upd(level_upd), .ack_active(ack_active));
	owb_device #(.ACK_PULSE_CYCLES(ACKP)) i_owb_device2 (.clk_sys(clk_sys), .reset(reset),
		.link(i_owb_link_if_b), .level(level2), .level_upd(level_upd2), .ack_active(ack_active2));
	owb_link_monitor #(.ACK_PULSE_CYCLES(ACKP)) i_owb_link_monitor (.clk_sys(clk_sys), .reset(reset),
		.host_oe(i_owb_link_if.host_oe), .dev_oe(i_owb_link_if.dev_oe), .wire_lvl(i_owb_link_if.wire_lvl));
	// Clock
	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Pulse counters and wire decoder; a short host low is a one, so is end-of-stream unless held low for an acknowledge request
	always @(posedge clk_sys) begin
		n_done += (done === 1'b1);
		n_upd2 += (level_upd2 === 1'b1);
		n_upd += (level_upd === 1'b1);
		n_ack += (ack_active === 1'b1);
		if (i_owb_link_if.host_oe === 1'b1) lo_cnt++;
		else if (lo_cnt > 0) begin
			wire_sh = {wire_sh[30:0], lo_cnt < 40};
			lo_cnt = 0;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	// One command word through the queue, then wait for its frame to finish
	task automatic frame(input logic [5:0] w);
		int k;
		k = n_done;
		cmd_data = w;
		cmd_valid = 1;
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		cmd_valid = 0;
		repeat (3000) if (n_done == k) @(negedge clk_sys);
		repeat (20) @(negedge clk_sys);
	endtask : frame
	// Bench plays host on the second wire; lo sets the short phase of each bit
	task automatic wbyte(input logic [7:0] b, input int nb, input int lo);
		for (int i = 7; i > 7 - nb; i--) begin
			i_owb_link_if_b.host_oe = 1;
			repeat (b[i] ? lo : 60) @(negedge clk_sys);
			i_owb_link_if_b.host_oe = 0;
			repeat (b[i] ? 60 : lo) @(negedge clk_sys);
		end
		i_owb_link_if_b.host_oe = 1;
		repeat (20) @(negedge clk_sys);
		i_owb_link_if_b.host_oe = 0;
		repeat (25) @(negedge clk_sys);
	endtask : wbyte
	task automatic bframe(input logic [7:0] a, input logic [7:0] d, input int nb, input int lo);
		wbyte(a, 8, 20);
		wbyte(d, nb, lo);
		// Long idle high so a partial byte is abandoned before the next frame
		repeat (100) @(negedge clk_sys);
	endtask : bframe
	// ----------------------------------------
	// Watchdog and main sequence
	// ----------------------------------------
	initial begin
		repeat (90000) @(posedge clk_sys);
		fails++;
		$display("MISMATCH %0t watchdog expired", $time);
		finish_test();
	end
	initial begin
		{cmd_valid, cmd_data, refused} = '0;
		i_owb_link_if_b.host_oe = 0;
		open_drain = 1;
		reset = 1;
		repeat (6) @(negedge clk_sys);
		reset = 0;
		check(level, 5'h00);
		// Faulty far side: wire already high, so the first byte needs no start
		bframe(8'h5A, 8'h07, 8, 20);
		check(level2, 5'h07);
		bframe(8'h33, 8'h0C, 8, 20);
		check(level2, 5'h07);
		bframe(8'h5A, 8'h0C, 7, 20);
		check(level2, 5'h07);
		bframe(8'h5A, 8'h0C, 8, 40);
		check(level2, 5'h07);
		check(n_upd2, 1);
		check(ack_active2, 0);
		// Design host to design device
		frame(6'h15);
		check(wire_sh[17:0], {8'h5A, 1'b1, 8'h15, 1'b1});
		check(level, 5'h15);
		check(acked, 0);
		open_drain = 0;
		frame(6'h2A);
		check(wire_sh[8:0], {8'h0A, 1'b1});
		check(acked, 0);
		open_drain = 1;
		frame(6'h33);
		check(acked, 1);
		check(level, 5'h13);
		check(n_ack, ACKP);
		// Fill the queue until it refuses, then let the wire drain it
		n = n_done;
		cmd_valid = 1;
		repeat (40) begin
			cmd_data = {1'b0, acc[4:0]};
			if (cmd_ready === 1'b1) acc++;
			else refused = 1;
			@(negedge clk_sys);
		end
		cmd_valid = 0;
		check(refused, 1);
		repeat (70000) if (n_done < n + acc) @(negedge clk_sys);
		repeat (20) @(negedge clk_sys);
		lexp = 5'(acc - 1);
		check(n_done, n + acc);
		check(level, lexp);
		check(n_upd, 3 + acc);
		check(busy, 0);
		finish_test();
	end
endmodule : one_wire_brightness_cmd_receiver_tb
